// *** src/mdds_pkg.sv ***
// Package: constants, types and register map of the data move decode unit
//
// Summary of operation
// - Enabled map sends 0000h-03FFh to on-chip SRAM
// - Map 01b sends above 03FFh to external bus
// - Disabled map (reset) sends everything external
// - Map select in power management bits 1:0
// - Full map: SRAM low, FFFCh reads lock byte
// - Full map reserved addresses make no bus cycle
// - Lock byte bits 2:0 show programmed locks
// - Map changes never alter stored SRAM contents
// - SRAM accesses always take two machine cycles
// - Three-bit stretch in clock control bits 2:0
// - External data access lasts stretch plus two
// - Strobe is 2 clocks, else four per stretch
// - Stretch resets to one: three-cycle access
// - Nonzero stretch adds one clock setup, hold
// - Program fetches ignore the stretch setting
package mdds_pkg;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam logic [7:0]  SFR_CLOCK_CONTROL   = 8'h8E;
  localparam logic [7:0]  SFR_POWER_MGMT      = 8'hC4;
  localparam logic [2:0]  STRETCH_RESET       = 3'h1;
  localparam logic [1:0]  MAP_RESET           = 2'h0;
  localparam int          STRETCH_LSB         = 0;
  localparam int          MAP_SEL_LO_BIT      = 0;
  localparam int          MAP_SEL_HI_BIT      = 1;
  localparam logic [7:0]  SFR_READ_NONE       = 8'h00;

  // ----------------------------------------------------------------------
  // Data address decode
  // ----------------------------------------------------------------------
  localparam logic [1:0]  MAP_EXT_ONLY        = 2'h0;
  localparam logic [1:0]  MAP_SRAM            = 2'h1;
  localparam logic [1:0]  MAP_SRAM_LOCK       = 2'h3;
  localparam logic [15:0] SRAM_LAST           = 16'h03FF;
  localparam logic [15:0] LOCK_ADDR           = 16'hFFFC;
  localparam int          SRAM_AW             = 10;
  localparam int          SRAM_DEPTH          = 1024;

  // ----------------------------------------------------------------------
  // Timing in oscillator clocks
  // ----------------------------------------------------------------------
  localparam logic [5:0]  CLK_PER_MC          = 6'h04;
  localparam logic [5:0]  BASE_MC             = 6'h02;
  localparam logic [5:0]  INT_LAST            = 6'h07;
  localparam logic [5:0]  ALE_CLKS            = 6'h02;
  localparam logic [5:0]  ADDR_P0_END         = 6'h03;
  localparam logic [5:0]  STRB_BEGIN0         = 6'h03;
  localparam logic [5:0]  SETUP_EXTRA         = 6'h01;
  localparam logic [5:0]  STRB_W0             = 6'h02;
  localparam logic [5:0]  STRB_W_STEP         = 6'h04;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    MDDS_ST_IDLE = 3'b001,
    MDDS_ST_BUS  = 3'b010,
    MDDS_ST_INT  = 3'b100
  } mdds_state_t;

  typedef enum logic [3:0] {
    MDDS_RG_EXT  = 4'b0001,
    MDDS_RG_SRAM = 4'b0010,
    MDDS_RG_LOCK = 4'b0100,
    MDDS_RG_RSVD = 4'b1000
  } mdds_region_t;

  typedef struct packed {
    logic        code;
    logic        wr;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } mdds_req_t;

endpackage

// *** src/mdds_cycle_cnt.sv ***
// Clock counter that paces one access from zero up to a loaded last value
`timescale 1ns/1ps
`default_nettype none
module mdds_cycle_cnt (
  input  wire logic       clk_sys,
  input  wire logic       nrst,
  input  wire logic       ce,
  input  wire logic       start,
  input  wire logic       run,
  input  wire logic [5:0] last,
  output logic      [5:0] cnt,
  output logic            at_last
);

  assign at_last = (cnt == last);

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      cnt <= 6'h00;
    end else if (ce) begin
      if (start) begin
        cnt <= 6'h00;
      end else if (run && !at_last) begin
        cnt <= cnt + 6'h01;
      end
    end
  end

endmodule
`default_nettype wire

// *** src/mdds_sram.sv ***
// On-chip 1KB data SRAM with registered read port
`timescale 1ns/1ps
`default_nettype none
module mdds_sram (
  input  wire logic                       clk_sys,
  input  wire logic                       ce,
  input  wire logic                       we,
  input  wire logic [mdds_pkg::SRAM_AW-1:0] addr,
  input  wire logic [7:0]                 wdata,
  output logic      [7:0]                 rdata
);

  // No reset: contents survive anything but a write
  logic [7:0] mem [mdds_pkg::SRAM_DEPTH];

  always_ff @(posedge clk_sys) begin
    if (ce) begin
      if (we) begin
        mem[addr] <= wdata;
      end
      rdata <= mem[addr];
    end
  end

endmodule
`default_nettype wire

// *** src/mdds_top.sv ***
// Data move unit: address decode, SFR controls, stretched external bus
`timescale 1ns/1ps
`default_nettype none
module mdds_top (
  input  wire logic                clk_sys,
  input  wire logic                nrst,
  input  wire logic                ce,
  input  wire logic                req_valid,
  input  wire mdds_pkg::mdds_req_t req,
  output logic                     busy,
  output logic                     done,
  output logic [7:0]               rdata,
  input  wire logic                sfr_wr,
  input  wire logic                sfr_rd,
  input  wire logic [7:0]          sfr_addr,
  input  wire logic [7:0]          sfr_wdata,
  output logic [7:0]               sfr_rdata,
  input  wire logic [2:0]          lock_bits,
  output logic [7:0]               p0_out,
  output logic                     p0_oe,
  input  wire logic [7:0]          p0_in,
  output logic [7:0]               p2_out,
  output logic                     ale,
  output logic                     rd_n,
  output logic                     wr_n,
  output logic                     psen_n
);

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  mdds_pkg::mdds_state_t  state;
  mdds_pkg::mdds_region_t region_q;
  mdds_pkg::mdds_region_t next_region;
  logic [2:0]  stretch;
  logic [1:0]  data_map_sel;
  logic        wr_q;
  logic        code_q;
  logic [15:0] addr_q;
  logic [7:0]  wdata_q;
  logic [2:0]  s_q;
  logic [5:0]  last_q;
  logic [5:0]  sb_q;
  logic [5:0]  se_q;
  logic [7:0]  bus_rd_q;
  logic [5:0]  cnt;
  logic        at_last;
  logic        accept;
  logic        in_bus;
  logic        strobe_on;
  logic        sram_we;
  logic [7:0]  sram_rdata;
  logic [2:0]  next_s;
  logic        data_map_sel_hi;
  logic        data_map_sel_lo;

  assign data_map_sel_hi = data_map_sel[mdds_pkg::MAP_SEL_HI_BIT];
  assign data_map_sel_lo = data_map_sel[mdds_pkg::MAP_SEL_LO_BIT];

  // ----------------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------------
  function automatic mdds_pkg::mdds_region_t decode(
    input logic [1:0]  map,
    input logic [15:0] a,
    input logic        code
  );
    mdds_pkg::mdds_region_t r;
    r = mdds_pkg::MDDS_RG_EXT;
    // Program fetches always leave the part here
    if (!code) begin
      case (map)
        mdds_pkg::MAP_SRAM: begin
          if (a <= mdds_pkg::SRAM_LAST) r = mdds_pkg::MDDS_RG_SRAM;
          else r = mdds_pkg::MDDS_RG_EXT;
        end
        mdds_pkg::MAP_SRAM_LOCK: begin
          if (a <= mdds_pkg::SRAM_LAST) r = mdds_pkg::MDDS_RG_SRAM;
          else if (a == mdds_pkg::LOCK_ADDR) r = mdds_pkg::MDDS_RG_LOCK;
          else r = mdds_pkg::MDDS_RG_RSVD;
        end
        default: r = mdds_pkg::MDDS_RG_EXT;
      endcase
    end
    return r;
  endfunction

  assign next_region = decode({data_map_sel_hi, data_map_sel_lo},
                              req.addr, req.code);
  assign accept = req_valid && (state == mdds_pkg::MDDS_ST_IDLE);
  // Fetches run at the unstretched profile
  assign next_s = req.code ? 3'h0 : stretch;

  // ----------------------------------------------------------------------
  // Special function registers
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      stretch      <= mdds_pkg::STRETCH_RESET;
      data_map_sel <= mdds_pkg::MAP_RESET;
    end else if (ce && sfr_wr) begin
      if (sfr_addr == mdds_pkg::SFR_CLOCK_CONTROL) begin
        stretch <= sfr_wdata[mdds_pkg::STRETCH_LSB +: 3];
      end
      // Takes effect from the next accepted access; SRAM untouched
      if (sfr_addr == mdds_pkg::SFR_POWER_MGMT) begin
        data_map_sel <= sfr_wdata[mdds_pkg::MAP_SEL_LO_BIT +: 2];
      end
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      sfr_rdata <= mdds_pkg::SFR_READ_NONE;
    end else if (ce && sfr_rd) begin
      case (sfr_addr)
        mdds_pkg::SFR_CLOCK_CONTROL: sfr_rdata <= {5'h00, stretch};
        mdds_pkg::SFR_POWER_MGMT:    sfr_rdata <= {6'h00, data_map_sel};
        default:                     sfr_rdata <= mdds_pkg::SFR_READ_NONE;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Access sequencer
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      state <= mdds_pkg::MDDS_ST_IDLE;
      busy  <= 1'b0;
    end else if (ce) begin
      case (state)
        mdds_pkg::MDDS_ST_IDLE: begin
          if (accept) begin
            busy <= 1'b1;
            if (next_region == mdds_pkg::MDDS_RG_EXT) begin
              state <= mdds_pkg::MDDS_ST_BUS;
            end else begin
              state <= mdds_pkg::MDDS_ST_INT;
            end
          end
        end
        mdds_pkg::MDDS_ST_BUS, mdds_pkg::MDDS_ST_INT: begin
          if (at_last) begin
            state <= mdds_pkg::MDDS_ST_IDLE;
            busy  <= 1'b0;
          end
        end
        default: begin
          state <= mdds_pkg::MDDS_ST_IDLE;
          busy  <= 1'b0;
        end
      endcase
    end
  end

  // Access parameters are frozen at acceptance, so a stretch or map
  // rewrite in mid-access cannot tear a cycle apart.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      region_q <= mdds_pkg::MDDS_RG_EXT;
      wr_q     <= 1'b0;
      code_q   <= 1'b0;
      addr_q   <= 16'h0000;
      wdata_q  <= 8'h00;
      s_q      <= 3'h0;
      last_q   <= mdds_pkg::INT_LAST;
      sb_q     <= mdds_pkg::STRB_BEGIN0;
      se_q     <= mdds_pkg::STRB_BEGIN0 + mdds_pkg::STRB_W0;
    end else if (ce && accept) begin
      region_q <= next_region;
      wr_q     <= req.wr;
      code_q   <= req.code;
      addr_q   <= req.addr;
      wdata_q  <= req.wdata;
      s_q      <= next_s;
      if (next_region == mdds_pkg::MDDS_RG_EXT) begin
        last_q <= 6'((6'(next_s) + mdds_pkg::BASE_MC)
                  * mdds_pkg::CLK_PER_MC - 6'h01);
      end else begin
        last_q <= mdds_pkg::INT_LAST;
      end
      if (next_s == 3'h0) begin
        sb_q <= mdds_pkg::STRB_BEGIN0;
        se_q <= mdds_pkg::STRB_BEGIN0 + mdds_pkg::STRB_W0;
      end else begin
        sb_q <= mdds_pkg::STRB_BEGIN0 + mdds_pkg::SETUP_EXTRA;
        se_q <= 6'(mdds_pkg::STRB_BEGIN0 + mdds_pkg::SETUP_EXTRA
                + 6'(next_s) * mdds_pkg::STRB_W_STEP);
      end
    end
  end

  mdds_cycle_cnt u_cnt (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .ce      (ce),
    .start   (accept),
    .run     (state != mdds_pkg::MDDS_ST_IDLE),
    .last    (last_q),
    .cnt     (cnt),
    .at_last (at_last)
  );

  // ----------------------------------------------------------------------
  // On-chip SRAM
  // ----------------------------------------------------------------------
  assign sram_we = (state == mdds_pkg::MDDS_ST_INT) && wr_q
                   && (region_q == mdds_pkg::MDDS_RG_SRAM)
                   && (cnt == 6'h00);

  mdds_sram u_sram (
    .clk_sys (clk_sys),
    .ce      (ce),
    .we      (sram_we),
    .addr    (addr_q[mdds_pkg::SRAM_AW-1:0]),
    .wdata   (wdata_q),
    .rdata   (sram_rdata)
  );

  // ----------------------------------------------------------------------
  // External bus pins
  // ----------------------------------------------------------------------
  assign in_bus    = (state == mdds_pkg::MDDS_ST_BUS);
  assign strobe_on = in_bus && (cnt >= sb_q) && (cnt < se_q);

  // Pins trail the counter by one clock; all phases shift together
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      ale    <= 1'b0;
      rd_n   <= 1'b1;
      wr_n   <= 1'b1;
      psen_n <= 1'b1;
      p2_out <= 8'hFF;
      p0_out <= 8'hFF;
      p0_oe  <= 1'b0;
    end else if (ce) begin
      ale    <= in_bus && (cnt < mdds_pkg::ALE_CLKS);
      rd_n   <= !(strobe_on && !wr_q && !code_q);
      wr_n   <= !(strobe_on && wr_q && !code_q);
      psen_n <= !(strobe_on && code_q);
      p2_out <= in_bus ? addr_q[15:8] : 8'hFF;
      if (in_bus && (cnt < mdds_pkg::ADDR_P0_END)) begin
        p0_out <= addr_q[7:0];
        p0_oe  <= 1'b1;
      end else if (in_bus && wr_q && (cnt >= sb_q) && (cnt <= se_q)) begin
        // Data held one clock past the strobe for write hold
        p0_out <= wdata_q;
        p0_oe  <= 1'b1;
      end else begin
        p0_out <= 8'hFF;
        p0_oe  <= 1'b0;
      end
    end
  end

  // Sample on the last clock the strobe is seen low outside
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      bus_rd_q <= 8'h00;
    end else if (ce && in_bus && !wr_q && (cnt == se_q)) begin
      bus_rd_q <= p0_in;
    end
  end

  // ----------------------------------------------------------------------
  // Completion
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      done  <= 1'b0;
      rdata <= 8'h00;
    end else if (ce) begin
      done <= at_last && (state != mdds_pkg::MDDS_ST_IDLE);
      if (at_last && (state != mdds_pkg::MDDS_ST_IDLE)) begin
        if (wr_q) begin
          rdata <= 8'h00;
        end else begin
          case (region_q)
            mdds_pkg::MDDS_RG_SRAM: rdata <= sram_rdata;
            mdds_pkg::MDDS_RG_LOCK: rdata <= {5'h00, lock_bits};
            mdds_pkg::MDDS_RG_EXT:  rdata <= bus_rd_q;
            default:                rdata <= 8'h00;
          endcase
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // Assertions (all assume ce stays high through an access)
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst || !ce);

  logic       strb_vis;
  logic [5:0] strb_len;
  logic [5:0] bus_len;
  logic [5:0] exp_w;
  logic       sfr_seen;
  logic [2:0] sfr_wd_stretch;
  logic [1:0] sfr_wd_map;

  assign strb_vis       = !rd_n || !wr_n || !psen_n;
  assign exp_w          = (s_q == 3'h0) ? mdds_pkg::STRB_W0
                          : 6'(6'(s_q) * mdds_pkg::STRB_W_STEP);
  assign sfr_wd_stretch = sfr_wdata[2:0];
  assign sfr_wd_map     = sfr_wdata[1:0];

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      strb_len <= 6'h00;
      bus_len  <= 6'h00;
      sfr_seen <= 1'b0;
    end else if (ce) begin
      strb_len <= strb_vis ? strb_len + 6'h01 : 6'h00;
      bus_len  <= accept ? 6'h00 : bus_len + 6'(in_bus);
      if (sfr_wr && sfr_addr == mdds_pkg::SFR_CLOCK_CONTROL) sfr_seen <= 1'b1;
    end
  end

  AST_SRAM_ROUTE: assert property (accept && !req.code
      && data_map_sel_lo && req.addr <= mdds_pkg::SRAM_LAST
      |=> state == mdds_pkg::MDDS_ST_INT)
    else $error("low address with map on did not go to SRAM");
  AST_HIGH_EXT: assert property (accept && data_map_sel == 2'h1
      && req.addr > mdds_pkg::SRAM_LAST
      |=> state == mdds_pkg::MDDS_ST_BUS)
    else $error("high address did not go external");
  AST_DEFAULT_EXT: assert property (accept && !data_map_sel_lo
      |=> state == mdds_pkg::MDDS_ST_BUS ##1 ale)
    else $error("map off access did not go external");
  AST_RSVD_MAP: assert property (accept && data_map_sel == 2'h2
      |=> in_bus)
    else $error("reserved map code not treated as external");
  AST_MAP_WRITE: assert property (sfr_wr
      && sfr_addr == mdds_pkg::SFR_POWER_MGMT
      |=> data_map_sel == $past(sfr_wd_map))
    else $error("map bits not updated");
  AST_RSVD_NOBUS: assert property (accept
      && next_region == mdds_pkg::MDDS_RG_RSVD
      |=> (rd_n && wr_n && !ale)[*8])
    else $error("reserved address made a bus cycle");
  AST_LOCK_READ: assert property (done && !wr_q
      && region_q == mdds_pkg::MDDS_RG_LOCK
      |-> rdata == {5'h00, $past(lock_bits)})
    else $error("lock byte read wrong");
  AST_SRAM_WE: assert property (sram_we |-> $past(accept) && $past(req.wr)
      && $past(next_region) == mdds_pkg::MDDS_RG_SRAM)
    else $error("SRAM written outside an SRAM access");
  AST_INT_TWO_MC: assert property (accept
      && next_region != mdds_pkg::MDDS_RG_EXT ##1 ce[*8] |=> done)
    else $error("internal access not two machine cycles");
  AST_STRETCH_WR: assert property (sfr_wr
      && sfr_addr == mdds_pkg::SFR_CLOCK_CONTROL
      |=> stretch == $past(sfr_wd_stretch))
    else $error("stretch not updated");
  AST_EXT_LEN: assert property (done
      && region_q == mdds_pkg::MDDS_RG_EXT
      |-> bus_len == 6'((6'(s_q) + mdds_pkg::BASE_MC)
                    * mdds_pkg::CLK_PER_MC))
    else $error("external access length wrong");
  AST_STROBE_W: assert property ($fell(strb_vis)
      |-> strb_len == exp_w)
    else $error("strobe width wrong");
  AST_STRETCH_RST: assert property (!sfr_seen |-> stretch == 3'h1)
    else $error("stretch reset value wrong");
  AST_SETUP_S0: assert property ($rose(strb_vis) && s_q == 3'h0
      |-> $past(ale, 2) && !$past(ale, 1))
    else $error("unstretched setup wrong");
  AST_SETUP_SN: assert property ($rose(strb_vis) && s_q != 3'h0
      |-> $past(ale, 3) && !$past(ale, 2))
    else $error("stretched setup not one clock longer");
  AST_FETCH_W: assert property ($rose(psen_n)
      |-> strb_len == mdds_pkg::STRB_W0)
    else $error("fetch strobe was stretched");

  COV_EXT_READ: cover property (done && in_bus == 1'b0
      && region_q == mdds_pkg::MDDS_RG_EXT && !wr_q && s_q == 3'h7);
  COV_SRAM_WR: cover property (done && wr_q
      && region_q == mdds_pkg::MDDS_RG_SRAM);
  COV_LOCK_RD: cover property (done && region_q == mdds_pkg::MDDS_RG_LOCK);
  COV_FETCH: cover property (done && code_q);

endmodule
`default_nettype wire

// *** verification/mdds_ext_mem.sv ***
// External data memory model on the multiplexed port 0 and port 2 bus
`timescale 1ns/1ps
`default_nettype none
module mdds_ext_mem (
  input  wire logic       clk_sys,
  input  wire logic       ale,
  input  wire logic [7:0] p0_out,
  input  wire logic [7:0] p2_out,
  input  wire logic       rd_n,
  input  wire logic       wr_n,
  input  wire logic       psen_n,
  output logic      [7:0] p0_in
);
  logic [7:0]  mem [0:65535];
  logic [15:0] addr;
  logic [7:0]  last;

  // Address-derived fill, so every external read has a known value
  initial begin
    for (int i = 0; i < 65536; i++) begin
      mem[i] = 8'(i) ^ 8'(i >> 8) ^ 8'h5A;
    end
    addr = 16'h0000;
    last = 8'h00;
  end

  always @(posedge clk_sys) begin
    if (ale) begin
      addr <= {p2_out, p0_out};
    end
    if (!wr_n) begin
      mem[addr] <= p0_out;
    end
    if (!rd_n || !psen_n) begin
      last <= mem[addr];
    end
  end

  // Released bus shows the inverse of the last byte so stale data cannot match
  assign p0_in = (!rd_n || !psen_n) ? mem[addr] : ~last;
endmodule
`default_nettype wire

// *** verification/tb.sv ***
// Self-checking bench for the data move decode unit
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin n_fail++; \
  $display("BAD %0t got %0h exp %0h", $time, g, e); end end
module tb;
  logic                clk_sys;
  logic                nrst;
  logic                req_valid;
  mdds_pkg::mdds_req_t req;
  logic                busy, done, ale, rd_n, wr_n, psen_n, p0_oe;
  logic                sfr_wr, sfr_rd;
  logic [7:0]          sfr_addr, sfr_wdata, sfr_rdata, rdata, got;
  logic [7:0]          p0_out, p0_in, p2_out;
  logic [2:0]          lock_bits;
  logic                ce;
  int                  n_fail = 0;
  int                  num_checks = 0;
  int                  lat, sw, first, lastlow, ale_n, s, n_busy, n_oe;
  logic [15:0]         rsvd [4] = '{16'h0400, 16'hFFFB, 16'hFFFD, 16'hFFFF};

  mdds_top i_mdds_top (.clk_sys, .nrst, .ce, .req_valid, .req, .busy,
    .done, .rdata, .sfr_wr, .sfr_rd, .sfr_addr, .sfr_wdata, .sfr_rdata,
    .lock_bits, .p0_out, .p0_oe, .p0_in, .p2_out, .ale, .rd_n, .wr_n,
    .psen_n);
  mdds_ext_mem i_mdds_ext_mem (.clk_sys, .ale, .p0_out, .p2_out, .rd_n,
    .wr_n, .psen_n, .p0_in);

  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  function automatic logic [7:0] pat(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h5A;
  endfunction
  function automatic int ext_lat(input int st);
    return 4 * (st + 2) + 1;
  endfunction
  function automatic int sw_exp(input int st);
    return (st == 0) ? 2 : 4 * st;
  endfunction

  task automatic results();
    if (n_fail == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic sfr_w(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    sfr_wr = 1'b1;
    sfr_addr = a;
    sfr_wdata = d;
    @(negedge clk_sys);
    sfr_wr = 1'b0;
  endtask

  task automatic sfr_chk(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk_sys);
    sfr_rd = 1'b1;
    sfr_addr = a;
    @(negedge clk_sys);
    sfr_rd = 1'b0;
    `CHK(sfr_rdata, e)
  endtask

  // One access; counts cycles to done, strobe cycles and ALE-high cycles
  task automatic acc(input logic c, input logic w, input logic [15:0] a,
                     input logic [7:0] d);
    @(negedge clk_sys);
    req_valid = 1'b1;
    req = '{code: c, wr: w, addr: a, wdata: d};
    @(negedge clk_sys);
    req_valid = 1'b0;
    lat = 0;
    sw = 0;
    first = 0;
    lastlow = 0;
    ale_n = 0;
    n_busy = 0;
    n_oe = 0;
    for (int k = 1; k < 60 && lat == 0; k++) begin
      if (ale === 1'b1) ale_n++;
      if (busy === 1'b1) n_busy++;
      if (p0_oe === 1'b1) n_oe++;
      if (rd_n !== 1'b1 || wr_n !== 1'b1 || psen_n !== 1'b1) begin
        sw++;
        if (first == 0) first = k;
        lastlow = k;
      end
      if (done === 1'b1) begin
        lat = k;
        got = rdata;
      end else begin
        @(negedge clk_sys);
      end
    end
    if (lat == 0) begin
      n_fail++;
      results();
    end
  endtask

  task automatic chk_acc(input int el, input int es, input logic [7:0] er);
    `CHK(lat, el)
    `CHK(sw, es)
    `CHK(got, er)
    `CHK(n_busy, el - 1)
  endtask

  initial begin
    nrst = 1'b0;
    req_valid = 1'b0;
    req = '0;
    sfr_wr = 1'b0;
    sfr_rd = 1'b0;
    sfr_addr = 8'h00;
    sfr_wdata = 8'h00;
    lock_bits = 3'h5;
    ce = 1'b1;
    repeat (6) @(negedge clk_sys);
    nrst = 1'b1;
    sfr_chk(8'h8E, 8'h01);
    sfr_chk(8'hC4, 8'h00);
    sfr_chk(8'h55, 8'h00);
    acc(1'b0, 1'b1, 16'h0010, 8'h3C);
    chk_acc(13, 4, 8'h00);
    `CHK(n_oe, 8)
    acc(1'b0, 1'b0, 16'h0010, 8'h00);
    chk_acc(13, 4, 8'h3C);
    for (s = 0; s < 8; s++) begin
      sfr_w(8'h8E, 8'hF8 | 8'(s));
      sfr_chk(8'h8E, 8'(s));
      acc(1'b0, 1'b0, 16'hA5C3, 8'h00);
      chk_acc(ext_lat(s), sw_exp(s), pat(16'hA5C3));
      `CHK(first, (s == 0) ? 5 : 6)
      `CHK(lat - lastlow, (s == 0) ? 3 : 4)
      `CHK(n_oe, 3)
    end
    // A write while the clock enable is low must be lost
    ce = 1'b0;
    sfr_w(8'h8E, 8'h02);
    ce = 1'b1;
    sfr_chk(8'h8E, 8'h07);
    // Stretch stays at seven from here on
    sfr_w(8'hC4, 8'hFD);
    sfr_chk(8'hC4, 8'h01);
    acc(1'b0, 1'b1, 16'h03FF, 8'hA5);
    chk_acc(9, 0, 8'h00);
    acc(1'b0, 1'b0, 16'h03FF, 8'h00);
    chk_acc(9, 0, 8'hA5);
    acc(1'b0, 1'b0, 16'h0400, 8'h00);
    chk_acc(37, 28, pat(16'h0400));
    acc(1'b1, 1'b0, 16'h0010, 8'h00);
    chk_acc(9, 2, 8'h3C);
    sfr_w(8'hC4, 8'h03);
    acc(1'b0, 1'b0, 16'hFFFC, 8'h00);
    chk_acc(9, 0, 8'h05);
    acc(1'b0, 1'b1, 16'hFFFC, 8'hFF);
    lock_bits = 3'h2;
    acc(1'b0, 1'b0, 16'hFFFC, 8'h00);
    chk_acc(9, 0, 8'h02);
    for (int i = 0; i < 4; i++) begin
      acc(1'b0, 1'b1, rsvd[i], 8'h77);
      acc(1'b0, 1'b0, rsvd[i], 8'h00);
      chk_acc(9, 0, 8'h00);
      `CHK(ale_n, 0)
      `CHK(n_oe, 0)
    end
    acc(1'b0, 1'b0, 16'h03FF, 8'h00);
    chk_acc(9, 0, 8'hA5);
    sfr_w(8'hC4, 8'h02);
    acc(1'b0, 1'b0, 16'h03FF, 8'h00);
    chk_acc(37, 28, pat(16'h03FF));
    sfr_w(8'hC4, 8'h00);
    acc(1'b0, 1'b0, 16'hFFFB, 8'h00);
    chk_acc(37, 28, pat(16'hFFFB));
    sfr_w(8'hC4, 8'h01);
    acc(1'b0, 1'b0, 16'h03FF, 8'h00);
    chk_acc(9, 0, 8'hA5);
    results();
  end
endmodule
`default_nettype wire
